// File: led_strings_model.sv
`timescale 1ns/10ps
// ====
// two led strings: light counted only while both conduct
module led_strings_model (
  input  wire logic        mclk_in,
  input  wire logic        led_sink_a_in,
  input  wire logic        led_sink_b_in,
  input  wire logic        start_in,
  input  wire logic [15:0] window_in,
  output logic             done_out,
  output logic [15:0]      light_out
);
  logic [15:0] left;

  always_ff @(posedge mclk_in) begin
    done_out <= 1'b0;
    if (start_in) begin
      left      <= window_in;
      light_out <= 16'h0000;
    end else if (left != 16'h0000) begin
      left      <= left - 16'h0001;
      light_out <= light_out + 16'(led_sink_a_in & led_sink_b_in);
      done_out  <= (left == 16'h0001);
    end
  end
endmodule : led_strings_model

// File: tb.sv
`timescale 1ns/10ps
`include "wled_dim_defs.svh"
module tb;
  import wled_dim_pkg::*;
  localparam int SLOT [4] = '{4, 3, 2, 1};
  logic        mclk_in = 1'b0;
  logic        rst_in, undervoltage_lockout, scl, m_sda, sda_out, sda_oe;
  logic        sink_a, sink_b, boost, res_a, res_b;
  logic        start, p_done, r_ok;
  logic [15:0] window, p_light, r_val;
  logic [15:0] exp_q[$];
  int          fail_count = 0;
  int          n_checks = 0;
  wire         sda_in = m_sda & (sda_oe ? sda_out : 1'b1);

  always #5 mclk_in = ~mclk_in;

  wled_pwm_dimming_control #(
    .SLOT_CYCLES_0(20'h4), .SLOT_CYCLES_1(20'h3),
    .SLOT_CYCLES_2(20'h2), .SLOT_CYCLES_3(20'h1)
  ) i_wled_pwm_dimming_control (
    .mclk_in(mclk_in), .rst_in(rst_in), .undervoltage_lockout_in(undervoltage_lockout),
    .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe),
    .led_sink_a_out(sink_a), .led_sink_b_out(sink_b), .boost_enable_out(boost),
    .range_resistor_a_pin_out(res_a), .range_resistor_b_pin_out(res_b)
  );

  led_strings_model i_led_strings_model (
    .mclk_in(mclk_in), .led_sink_a_in(sink_a), .led_sink_b_in(sink_b),
    .start_in(start), .window_in(window), .done_out(p_done), .light_out(p_light)
  );

  // ====
  // result watcher
  task automatic cmp(input logic [15:0] got);
    logic [15:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
    n_checks++;
    if (got !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, e);
    end
  endtask : cmp

  always @(posedge mclk_in) begin
    if (p_done === 1'b1) cmp(p_light);
    if (r_ok === 1'b1) cmp(r_val);
  end

  // ====
  // serial bus master
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : tick

  task automatic post(input logic [15:0] v);
    r_val = v;
    r_ok  = 1'b1;
    tick(1);
    r_ok  = 1'b0;
  endtask : post

  task automatic bit_x(input logic b, output logic r);
    m_sda = b;
    tick(4);
    scl = 1'b1;
    tick(4);
    r = sda_in;
    scl = 1'b0;
    tick(4);
  endtask : bit_x

  task automatic byte_x(input logic [7:0] d, input logic mack, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
    bit_x(mack, a);
  endtask : byte_x

  task automatic sta;
    m_sda = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    m_sda = 1'b0;
    tick(4);
    scl = 1'b0;
    tick(4);
  endtask : sta

  task automatic sto;
    m_sda = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    m_sda = 1'b1;
    tick(4);
  endtask : sto

  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    logic [7:0] r;
    sta();
    byte_x({`DEV_ADDR_DEFAULT, 1'b0}, 1'b1, r);
    byte_x(off, 1'b1, r);
    byte_x(d, 1'b1, r);
    sto();
  endtask : wr

  task automatic rd(input logic [7:0] off, input logic [7:0] e);
    logic [7:0] r;
    exp_q.push_back({8'h00, e});
    sta();
    byte_x({`DEV_ADDR_DEFAULT, 1'b0}, 1'b1, r);
    byte_x(off, 1'b1, r);
    sta();
    byte_x({`DEV_ADDR_DEFAULT, 1'b1}, 1'b1, r);
    byte_x(8'hFF, 1'b1, r);
    sto();
    post({8'h00, r});
  endtask : rd

  // pins seen as {boost, range a, range b}
  task automatic pins(input logic [2:0] e);
    exp_q.push_back({13'h0000, e});
    post({13'h0000, boost, res_a, res_b});
  endtask : pins

  task automatic meas(input int win, input int e);
    exp_q.push_back(16'(e));
    window = 16'(win);
    start  = 1'b1;
    tick(1);
    start  = 1'b0;
    tick(win + 4);
  endtask : meas

  task automatic close_out;
    if (exp_q.size() != 0) fail_count++;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  // ====
  // main sequence
  initial begin
    logic [6:0] code;
    logic       rs;
    logic [6:0] codes [5];
    rst_in = 1'b1; undervoltage_lockout = 1'b0; scl = 1'b1; m_sda = 1'b1;
    start = 1'b0; window = 16'h0000; r_ok = 1'b0; r_val = 16'h0000;
    void'($urandom(32'h7ad8));
    tick(4);
    rst_in = 1'b0;
    tick(2);
    rd(8'h19, 8'h1E);
    rd(8'h18, 8'h10);
    pins(3'b001);
    wr(8'h18, 8'h90);
    pins(3'b101);
    tick(800);
    meas(900, 3 * 31 * 3);
    for (int f = 0; f < 4; f++) begin
      wr(8'h18, 8'h80 | 8'(f << 4));
      codes = '{7'h00, 7'h63, 7'h64, 7'h7F, 7'($urandom % 100)};
      for (int i = 0; i < 5; i++) begin
        code = codes[i];
        rs = 1'($urandom);
        wr(8'h19, {rs, code});
        pins({1'b1, rs, ~rs});
        rd(8'h19, {rs, code});
        tick(800);
        meas(300 * SLOT[f], (code > 7'h63) ? 0 : 3 * (code + 1) * SLOT[f]);
      end
    end
    wr(8'h19, 8'hE3);
    wr(8'h18, 8'h10);
    pins(3'b010);
    meas(100, 0);
    undervoltage_lockout = 1'b1;
    tick(5);
    undervoltage_lockout = 1'b0;
    tick(2);
    rd(8'h19, 8'h1E);
    rd(8'h18, 8'h10);
    pins(3'b001);
    close_out();
  end

  initial begin
    #900us;
    fail_count++;
    close_out();
  end
endmodule : tb

// File: wled_dim_defs.svh
`ifndef WLED_DIM_DEFS_SVH
`define WLED_DIM_DEFS_SVH

// ==========================================================
// register offsets
`define LED_CTRL_OFFSET      8'h18
`define LED_DIM_CTRL_OFFSET  8'h19

// ==========================================================
// field positions
`define SINK_ENABLE_POS      7
`define DIM_FREQ_MSB         5
`define DIM_FREQ_LSB         4
`define RANGE_SELECT_POS     7
`define DUTY_CODE_MSB        6

// ==========================================================
// reset values, loaded by reset and undervoltage lockout
`define LED_CTRL_DEFAULT     8'h10
`define LED_DIM_CTRL_DEFAULT 8'h1E

// ==========================================================
// duty encoding
`define DUTY_CODE_MAX        7'h63
`define DUTY_STEPS           100

// ==========================================================
// timing
`define CLK_HZ               100000000
`define DIM_FREQ_0_HZ        100
`define DIM_FREQ_1_HZ        200
`define DIM_FREQ_2_HZ        500
`define DIM_FREQ_3_HZ        1000
`define SLOT_CYCLES_0        (`CLK_HZ / (`DIM_FREQ_0_HZ * `DUTY_STEPS))
`define SLOT_CYCLES_1        (`CLK_HZ / (`DIM_FREQ_1_HZ * `DUTY_STEPS))
`define SLOT_CYCLES_2        (`CLK_HZ / (`DIM_FREQ_2_HZ * `DUTY_STEPS))
`define SLOT_CYCLES_3        (`CLK_HZ / (`DIM_FREQ_3_HZ * `DUTY_STEPS))

// ==========================================================
// serial port
`define DEV_ADDR_DEFAULT     7'h2A

`endif

// File: wled_dim_pkg.sv
package wled_dim_pkg;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b011,
    ST_WR_BYTE  = 3'b010,
    ST_WR_ACK   = 3'b110,
    ST_RD_BYTE  = 3'b111,
    ST_RD_ACK   = 3'b101
  } port_state_t;

  typedef struct packed {
    logic       range_select;
    logic [6:0] dim_duty_code;
  } dim_ctrl_t;

  typedef struct packed {
    logic       sink_enable;
    logic [1:0] dim_freq;
  } led_ctrl_t;

endpackage : wled_dim_pkg

// File: wled_pwm_dimming_control.sv
// Function
// - bit seven picks range resistor: 0 selects resistor b, 1 selects resistor a.
// - duty code 0 gives 1% on-time, code 99 gives 100%, 1% steps.
// - codes above 99 give 0% on-time, both sinks off all period.
// - default duty code gives 31%, range select defaults to 0.
// - undervoltage lockout restores all bits to default; dim control bits read/write, led control bits 6 and 3:0 read 0.
// - enable, duty and dimming frequency programmable, taking effect without trigger.
// - sink enable bit turns boost on or off and, when clear, holds both sinks off regardless of duty.
// - PWM switches both sinks together, default repetition rate 200 Hz.
`timescale 1ns/10ps
`include "wled_dim_defs.svh"

module wled_pwm_dimming_control #(
  parameter logic [6:0]  DEV_ADDR      = `DEV_ADDR_DEFAULT, // arbitrary bus address
  parameter logic [19:0] SLOT_CYCLES_0 = 20'(`SLOT_CYCLES_0),
  parameter logic [19:0] SLOT_CYCLES_1 = 20'(`SLOT_CYCLES_1),
  parameter logic [19:0] SLOT_CYCLES_2 = 20'(`SLOT_CYCLES_2),
  parameter logic [19:0] SLOT_CYCLES_3 = 20'(`SLOT_CYCLES_3)
) (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic undervoltage_lockout_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  output logic      led_sink_a_out,
  output logic      led_sink_b_out,
  output logic      boost_enable_out,
  output logic      range_resistor_a_pin_out,
  output logic      range_resistor_b_pin_out
);
  import wled_dim_pkg::*;
  localparam logic [7:0] CTRL_DEF  = `LED_CTRL_DEFAULT;
  localparam led_ctrl_t  CTRL_INIT = {CTRL_DEF[`SINK_ENABLE_POS], CTRL_DEF[`DIM_FREQ_MSB:`DIM_FREQ_LSB]};

  // ==========================================================
  // helpers
  function automatic logic [6:0] duty_slots(input logic [6:0] code);
    duty_slots = (code > `DUTY_CODE_MAX) ? 7'h00 : 7'(code + 7'h01);
  endfunction : duty_slots
  function automatic logic [19:0] slot_len(input logic [1:0] sel);
    unique case (sel)
      2'b00: slot_len = SLOT_CYCLES_0;
      2'b01: slot_len = SLOT_CYCLES_1;
      2'b10: slot_len = SLOT_CYCLES_2;
      2'b11: slot_len = SLOT_CYCLES_3;
    endcase
  endfunction : slot_len

  // ==========================================================
  // serial port line events
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  assign scl_rise   = scl_in & ~scl_q;
  assign scl_fall   = ~scl_in & scl_q;
  assign start_seen = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_seen  = scl_in & scl_q & ~sda_q & sda_in;

  // ==========================================================
  // serial port state and registers
  port_state_t state;
  port_state_t next_state;
  logic [7:0]  shift;
  logic [7:0]  next_shift;
  logic [2:0]  bit_cnt;
  logic [2:0]  next_bit_cnt;
  logic        byte_done;
  logic        next_byte_done;
  logic        first_byte;
  logic        next_first_byte;
  logic        nack;
  logic        next_nack;
  logic [7:0]  ptr;
  logic [7:0]  next_ptr;
  logic        oe;
  logic        next_oe;
  dim_ctrl_t   dim;
  dim_ctrl_t   next_dim;
  led_ctrl_t   ctrl;
  led_ctrl_t   next_ctrl;
  logic        wr_dim;
  logic [7:0]  rd_byte;

  function automatic logic [7:0] reg_read(input logic [7:0] a, input led_ctrl_t c, input dim_ctrl_t d);
    reg_read = 8'h00;
    if (a == `LED_CTRL_OFFSET)
      reg_read = {c.sink_enable, 1'b0, c.dim_freq, 4'h0};
    else if (a == `LED_DIM_CTRL_OFFSET)
      reg_read = d;
  endfunction : reg_read
  assign rd_byte = reg_read(ptr, ctrl, dim);
  always_comb begin
    next_state      = state;
    next_shift      = shift;
    next_bit_cnt    = bit_cnt;
    next_byte_done  = byte_done;
    next_first_byte = first_byte;
    next_nack       = nack;
    next_ptr        = ptr;
    next_oe         = oe;
    next_dim        = dim;
    next_ctrl       = ctrl;
    wr_dim          = 1'b0;
    unique case (state)
      ST_IDLE: ;
      ST_ADDR, ST_WR_BYTE: begin
        if (scl_rise && !byte_done) begin
          next_shift     = {shift[6:0], sda_in};
          next_bit_cnt   = 3'(bit_cnt + 3'h1);
          next_byte_done = (bit_cnt == 3'h7);
        end else if (scl_fall && byte_done) begin
          next_byte_done = 1'b0;
          if (state == ST_ADDR) begin
            next_state = (shift[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
            next_oe    = (shift[7:1] == DEV_ADDR);
            next_nack  = shift[0];
          end else begin
            next_state = ST_WR_ACK;
            next_oe    = 1'b1;
            if (first_byte) begin
              next_ptr = shift;
            end else begin
              next_ptr = 8'(ptr + 8'h01);
              if (ptr == `LED_DIM_CTRL_OFFSET) begin
                next_dim = shift;
                wr_dim   = 1'b1;
              end else if (ptr == `LED_CTRL_OFFSET) begin
                next_ctrl = {shift[`SINK_ENABLE_POS], shift[`DIM_FREQ_MSB:`DIM_FREQ_LSB]};
              end
            end
            next_first_byte = 1'b0;
          end
        end
      end
      ST_ADDR_ACK, ST_WR_ACK: begin
        if (scl_fall) begin
          next_bit_cnt = 3'h0;
          if (state == ST_ADDR_ACK && nack) begin
            next_state = ST_RD_BYTE;
            next_shift = rd_byte;
            next_oe    = ~rd_byte[7];
          end else begin
            next_state = ST_WR_BYTE;
            next_oe    = 1'b0;
            if (state == ST_ADDR_ACK)
              next_first_byte = 1'b1;
          end
        end
      end
      ST_RD_BYTE: begin
        if (scl_fall) begin
          next_bit_cnt = 3'(bit_cnt + 3'h1);
          next_shift   = {shift[6:0], 1'b0};
          next_oe      = ~shift[6];
          if (bit_cnt == 3'h7) begin
            next_state = ST_RD_ACK;
            next_oe    = 1'b0;
            next_ptr   = 8'(ptr + 8'h01);
          end
        end
      end
      ST_RD_ACK: begin
        if (scl_rise) begin
          next_nack = sda_in;
        end else if (scl_fall) begin
          next_bit_cnt = 3'h0;
          next_state   = nack ? ST_IDLE : ST_RD_BYTE;
          next_shift   = rd_byte;
          next_oe      = nack ? 1'b0 : ~rd_byte[7];
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (start_seen) begin
      next_state     = ST_ADDR;
      next_bit_cnt   = 3'h0;
      next_byte_done = 1'b0;
      next_oe        = 1'b0;
    end else if (stop_seen) begin
      next_state = ST_IDLE;
      next_oe    = 1'b0;
    end
    if (undervoltage_lockout_in) begin
      next_dim  = `LED_DIM_CTRL_DEFAULT;
      next_ctrl = CTRL_INIT;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      state      <= ST_IDLE;
      shift      <= 8'h00;
      bit_cnt    <= 3'h0;
      byte_done  <= 1'b0;
      first_byte <= 1'b0;
      nack       <= 1'b0;
      ptr        <= 8'h00;
      oe         <= 1'b0;
      dim        <= `LED_DIM_CTRL_DEFAULT;
      ctrl       <= CTRL_INIT;
    end else begin
      scl_q      <= scl_in;
      sda_q      <= sda_in;
      state      <= next_state;
      shift      <= next_shift;
      bit_cnt    <= next_bit_cnt;
      byte_done  <= next_byte_done;
      first_byte <= next_first_byte;
      nack       <= next_nack;
      ptr        <= next_ptr;
      oe         <= next_oe;
      dim        <= next_dim;
      ctrl       <= next_ctrl;
    end
  end

  // ==========================================================
  // dimming pwm: 100 slots per period
  logic [19:0] slot_cnt;
  logic [19:0] next_slot_cnt;
  logic [6:0]  slot_idx;
  logic [6:0]  next_slot_idx;
  logic [6:0]  on_slots;
  logic [6:0]  next_on_slots;
  logic [1:0]  freq_q;
  logic [1:0]  next_freq_q;
  logic        period_end;
  logic        next_sink;
  assign period_end = (slot_idx == 7'(`DUTY_STEPS - 1)) && (slot_cnt >= 20'(slot_len(freq_q) - 20'h1));
  always_comb begin
    next_slot_cnt = 20'(slot_cnt + 20'h1);
    next_slot_idx = slot_idx;
    next_on_slots = on_slots;
    next_freq_q   = freq_q;
    if (slot_cnt >= 20'(slot_len(freq_q) - 20'h1)) begin
      next_slot_cnt = 20'h0;
      next_slot_idx = 7'(slot_idx + 7'h1);
    end
    if (period_end) begin
      next_slot_idx = 7'h0;
      next_on_slots = duty_slots(dim.dim_duty_code);
      next_freq_q   = ctrl.dim_freq;
    end
    next_sink = ctrl.sink_enable && (next_slot_idx < next_on_slots);
  end
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      slot_cnt                 <= 20'h0;
      slot_idx                 <= 7'h0;
      on_slots                 <= duty_slots(7'(`LED_DIM_CTRL_DEFAULT));
      freq_q                   <= CTRL_INIT.dim_freq;
      led_sink_a_out           <= 1'b0;
      led_sink_b_out           <= 1'b0;
      boost_enable_out         <= 1'b0;
      range_resistor_a_pin_out <= 1'b0;
      range_resistor_b_pin_out <= 1'b1;
      sda_out                  <= 1'b0;
      sda_oe_out               <= 1'b0;
    end else begin
      slot_cnt                 <= next_slot_cnt;
      slot_idx                 <= next_slot_idx;
      on_slots                 <= next_on_slots;
      freq_q                   <= next_freq_q;
      led_sink_a_out           <= next_sink;
      led_sink_b_out           <= next_sink;
      boost_enable_out         <= ctrl.sink_enable;
      range_resistor_a_pin_out <= next_dim.range_select;
      range_resistor_b_pin_out <= ~next_dim.range_select;
      sda_out                  <= 1'b0;
      sda_oe_out               <= next_oe;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  chk_range_pins: assert property (range_resistor_a_pin_out == dim.range_select && range_resistor_b_pin_out != dim.range_select) else $error("range pin mismatch");
  chk_duty_latch: assert property (period_end && dim.dim_duty_code <= 7'h63 |=> on_slots == $past(dim.dim_duty_code) + 7'h01) else $error("duty map wrong");
  chk_overrange_off: assert property (period_end && dim.dim_duty_code > 7'h63 |=> on_slots == 7'h00 ##1 !led_sink_a_out[*8]) else $error("overrange not off");
  chk_undervoltage_lockout_default: assert property (undervoltage_lockout_in |=> dim == 8'h1E && ctrl.dim_freq == 2'b01 && !ctrl.sink_enable) else $error("lockout default missing");
  chk_dim_write: assert property (wr_dim && !undervoltage_lockout_in |=> dim == $past(shift) ##1 range_resistor_a_pin_out == dim.range_select) else $error("write not stored");
  chk_enable_off: assert property (!ctrl.sink_enable |=> !led_sink_a_out && !led_sink_b_out && !boost_enable_out) else $error("sinks on while disabled");
  chk_sinks_together: assert property (led_sink_a_out == led_sink_b_out) else $error("sinks differ");
  chk_hold_midperiod: assert property (!period_end |=> $stable(on_slots) && $stable(freq_q)) else $error("duty changed mid period");
  chk_full_duty: assert property (ctrl.sink_enable && on_slots == 7'h64 && !period_end |=> led_sink_a_out) else $error("full duty gap");
  cov_full_duty: cover property (period_end && dim.dim_duty_code == 7'h63);
  cov_overrange: cover property (period_end && dim.dim_duty_code > 7'h63);
  cov_dim_write: cover property (wr_dim);
  cov_read_ack: cover property (state == ST_RD_ACK && scl_fall);
endmodule : wled_pwm_dimming_control
